// file: src/ctrl_delay_line.sv
`timescale 1ns/100ps
`include "trap_unit_map.svh"
// holds pending control register writes until three instructions retire
module ctrl_delay_line
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // write side
  input  wire logic        wrValid,
  input  wire logic [3:0]  wrAddr,
  input  wire logic [31:0] wrData,
  input  wire logic        instrStep,
  // retire side
  output logic             outValid,
  output logic [3:0]       outAddr,
  output logic [31:0]      outData
);
  logic [3:0]  addr_q [3];
  logic [31:0] data_q [3];
  logic [2:0]  valid_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      valid_q <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        addr_q[i] <= 4'h0;
        data_q[i] <= 32'h0000_0000;
      end
    end
    else if (instrStep || wrValid)
    begin
      valid_q[0] <= wrValid;
      addr_q[0]  <= wrAddr;
      data_q[0]  <= wrData;
      if (instrStep)
      begin
        valid_q[2:1] <= valid_q[1:0];
        addr_q[1]    <= addr_q[0];
        addr_q[2]    <= addr_q[1];
        data_q[1]    <= data_q[0];
        data_q[2]    <= data_q[1];
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      outValid <= 1'b0;
      outAddr  <= 4'h0;
      outData  <= 32'h0000_0000;
    end
    else
    begin
      outValid <= instrStep & valid_q[2];
      outAddr  <= addr_q[2];
      outData  <= data_q[2];
    end
  end
endmodule : ctrl_delay_line

// file: src/trap_and_interrupt_unit.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "trap_unit_map.svh"
module trap_and_interrupt_unit
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // interrupt request pins, one per level (bit 0 unused)
  input  wire logic [15:1]                 irqLevel,
  // pipeline side
  input  wire logic                        execValid,
  input  wire trap_unit_pkg::exc_cause_type excCause,
  input  wire trap_unit_pkg::exc_info_type  excInfo,
  input  wire logic                        refillWordDone,
  input  wire logic                        returnFromTrap,
  input  wire logic                        returnSkip,
  // register port
  input  wire logic [3:0]                  regAddr,
  input  wire logic [31:0]                 regWrData,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic [31:0]                      regRdData,
  // pipeline control
  output logic                             flushPipe,
  output logic                             instrCommit,
  output logic                             redirectValid,
  output logic [31:0]                      redirectPc,
  output logic                             refillAbort,
  output logic                             tagOverflowFlag,
  output logic [7:0]                       trapTypeOut
);
  // ==========================================================
  // state
  // ==========================================================
  logic [31:0] trapBaseReg_q;
  logic [31:0] stateReg_q;
  logic [`NUM_WINDOWS-1:0] winInvalid_q;
  logic [14:0] irqMask_q;
  logic        vectorModeAux_q;
  logic [31:0] savedPc_q;
  logic [31:0] savedNpc_q;
  logic [15:1] irqMeta_q;
  logic [15:1] irqSync_q;
  logic        dlyValid;
  logic [3:0]  dlyAddr;
  logic [31:0] dlyData;
  trap_unit_pkg::trap_state_type state_q;

  function automatic logic [2:0] wrapWin(input logic [2:0] w, input logic up);
    wrapWin = up ? w + 3'h1 : w - 3'h1;
  endfunction : wrapWin

  // ==========================================================
  // interrupt synchroniser and level select
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irqMeta_q <= 15'h0000;
      irqSync_q <= 15'h0000;
    end
    else
    begin
      irqMeta_q <= irqLevel;
      irqSync_q <= irqMeta_q;
    end
  end

  logic        trapsOn;
  logic        superMode;
  logic [2:0]  current_window_ptr;
  logic [15:1] irqLive;
  logic [3:0]  irqPick;
  assign trapsOn   = stateReg_q[`PSR_ET_BIT];
  assign superMode = stateReg_q[`PSR_S_BIT];
  assign current_window_ptr       = stateReg_q[`PSR_CWP_MSB:`PSR_CWP_LSB];
  // level 15 bypasses the mask; lower levels gated by their mask bit
  assign irqLive = {irqSync_q[15], irqSync_q[14:1] & ~irqMask_q[14:1]};

  always_comb
  begin
    irqPick = 4'h0;
    for (int n = 1; n <= 15; n++)
      if (irqLive[n])
        irqPick = n[3:0];
  end

  // ==========================================================
  // synchronous trap decode and priority
  // ==========================================================
  logic        misaligned;
  logic        tagBad;
  logic        winBad;
  logic        anyTrap;
  logic [7:0]  tt;
  always_comb
  begin
    case (excCause.accessSize)
      2'h1:    misaligned = excInfo.addr[0];
      2'h2:    misaligned = |excInfo.addr[1:0];
      2'h3:    misaligned = |excInfo.addr[2:0];
      default: misaligned = 1'b0;
    endcase
  end
  assign tagBad = |excInfo.opA[1:0] | |excInfo.opB[1:0];
  assign winBad = (excCause.saveInstr & winInvalid_q[wrapWin(current_window_ptr, 1'b0)]) |
                  (excCause.restoreInstr & winInvalid_q[wrapWin(current_window_ptr, 1'b1)]);

  always_comb
  begin
    anyTrap = 1'b1;
    tt      = 8'h00;
    if (execValid && excCause.breakpoint)
      tt = `TT_BREAKPOINT;
    else if (execValid && excCause.instAccess)
      tt = `TT_INST_ACCESS;
    else if (execValid && excCause.privAsi && !superMode)
      tt = `TT_PRIVILEGED;
    else if (execValid && excCause.illegal)
      tt = `TT_ILLEGAL;
    else if (execValid && excCause.fpInstr)
      tt = `TT_FP_DISABLED;
    else if (execValid && excCause.cpInstr)
      tt = `TT_CP_DISABLED;
    else if (execValid && excCause.saveInstr && winBad)
      tt = `TT_WIN_OVERFLOW;
    else if (execValid && excCause.restoreInstr && winBad)
      tt = `TT_WIN_UNDERFLOW;
    else if (execValid && excCause.memAccess && misaligned)
      tt = `TT_NOT_ALIGNED;
    else if (execValid && excCause.dataAccess)
      tt = `TT_DATA_ACCESS;
    else if (execValid && excCause.tagTrapOp && tagBad)
      tt = `TT_TAG_OVERFLOW;
    else if (execValid && excCause.ticcTaken)
      tt = `TT_TICC_BASE | {1'b0, excCause.ticcNumber};
    else if (trapsOn && irqPick != 4'h0)
      tt = `TT_IRQ_BASE + {4'h0, irqPick};
    else
      anyTrap = 1'b0;
  end

  logic isIrq;
  logic takeTrap;
  assign isIrq    = tt[7:4] == 4'h1 && tt != 8'h10;
  // synchronous traps with traps disabled would enter error mode; held off here
  assign takeTrap = anyTrap && trapsOn && state_q == trap_unit_pkg::RUN;

  // ==========================================================
  // sequencer
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_q <= trap_unit_pkg::FETCH;
    else
    begin
      case (state_q)
        trap_unit_pkg::RUN:   state_q <= takeTrap ? trap_unit_pkg::ENTER
                                                  : trap_unit_pkg::RUN;
        trap_unit_pkg::ENTER: state_q <= trap_unit_pkg::FETCH;
        trap_unit_pkg::FETCH: state_q <= trap_unit_pkg::RUN;
        default:              state_q <= trap_unit_pkg::RUN;
      endcase
    end
  end

  // ==========================================================
  // pipeline outputs
  // ==========================================================
  logic [31:0] vectorAddr;
  always_comb
  begin
    if (vectorModeAux_q)
      vectorAddr = {trapBaseReg_q[`TBR_BASE_MSB:`TBR_BASE_LSB], 12'h000};
    else
      vectorAddr = {trapBaseReg_q[`TBR_BASE_MSB:`TBR_BASE_LSB], tt, 4'h0};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flushPipe       <= 1'b1;
      instrCommit     <= 1'b0;
      redirectValid   <= 1'b1;
      redirectPc      <= `RESET_VECTOR;
      refillAbort     <= 1'b0;
      tagOverflowFlag <= 1'b0;
      trapTypeOut     <= 8'h00;
    end
    else
    begin
      flushPipe       <= takeTrap;
      instrCommit     <= execValid && !takeTrap && state_q == trap_unit_pkg::RUN;
      redirectValid   <= takeTrap || (returnFromTrap && state_q == trap_unit_pkg::RUN);
      refillAbort     <= refillWordDone && takeTrap && isIrq;
      tagOverflowFlag <= execValid && excCause.tagTrapOp == 1'b0 && tagBad;
      if (takeTrap)
      begin
        redirectPc  <= vectorAddr;
        trapTypeOut <= tt;
      end
      else if (returnFromTrap)
        redirectPc  <= returnSkip ? savedNpc_q : savedPc_q;
    end
  end

  // ==========================================================
  // saved program counters
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      savedPc_q  <= 32'h0000_0000;
      savedNpc_q <= 32'h0000_0000;
    end
    else if (takeTrap)
    begin
      // both kinds name the instruction in execute: the causer, or the next to run
      savedPc_q  <= excInfo.pc;
      savedNpc_q <= excInfo.npc;
    end
  end

  // ==========================================================
  // control registers
  // ==========================================================
  ctrl_delay_line delayLine
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .wrValid   (regWrite && regAddr != `OFF_TRAP_STATUS),
    .wrAddr    (regAddr),
    .wrData    (regWrData),
    .instrStep (execValid || regWrite),
    .outValid  (dlyValid),
    .outAddr   (dlyAddr),
    .outData   (dlyData)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      trapBaseReg_q   <= 32'h0000_0000;
      stateReg_q      <= `RST_STATE;
      winInvalid_q    <= '0;
      irqMask_q       <= 15'h0000;
      vectorModeAux_q <= 1'b0;
    end
    else if (takeTrap)
    begin
      trapBaseReg_q[`TBR_TT_MSB:`TBR_TT_LSB] <= tt;
      stateReg_q[`PSR_ET_BIT] <= 1'b0;
      stateReg_q[`PSR_PS_BIT] <= superMode;
      stateReg_q[`PSR_S_BIT]  <= 1'b1;
      stateReg_q[`PSR_CWP_MSB:`PSR_CWP_LSB] <= wrapWin(current_window_ptr, 1'b0);
    end
    else if (returnFromTrap && state_q == trap_unit_pkg::RUN)
    begin
      stateReg_q[`PSR_ET_BIT] <= 1'b1;
      stateReg_q[`PSR_S_BIT]  <= stateReg_q[`PSR_PS_BIT];
      stateReg_q[`PSR_CWP_MSB:`PSR_CWP_LSB] <= wrapWin(current_window_ptr, 1'b1);
    end
    else if (dlyValid)
    begin
      case (dlyAddr)
        `OFF_TRAP_BASE:   trapBaseReg_q[`TBR_BASE_MSB:`TBR_BASE_LSB] <=
                            dlyData[`TBR_BASE_MSB:`TBR_BASE_LSB];
        `OFF_MASK:        irqMask_q <= {dlyData[14:1], 1'b0};
        `OFF_WIN_INVALID: winInvalid_q <= dlyData[`NUM_WINDOWS-1:0];
        `OFF_STATE:       stateReg_q <= dlyData;
        `OFF_VECTOR_MODE: vectorModeAux_q <= dlyData[0];
        default:          ;
      endcase
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h0000_0000;
    else if (regRead)
    begin
      case (regAddr)
        `OFF_TRAP_BASE:   regRdData <= trapBaseReg_q;
        `OFF_MASK:        regRdData <= {17'h0_0000, irqMask_q};
        `OFF_WIN_INVALID: regRdData <= {24'h00_0000, winInvalid_q};
        `OFF_STATE:       regRdData <= stateReg_q;
        `OFF_VECTOR_MODE: regRdData <= {31'h0000_0000, vectorModeAux_q};
        `OFF_TRAP_STATUS: regRdData <= {16'h0000, irqSync_q, 1'b0};
        `OFF_SAVED_PC:    regRdData <= savedPc_q;
        `OFF_SAVED_NPC:   regRdData <= savedNpc_q;
        default:          regRdData <= 32'h0000_0000;
      endcase
    end
    else
      regRdData <= 32'h0000_0000;
  end
endmodule : trap_and_interrupt_unit

// file: src/trap_unit_map.svh
`ifndef TRAP_UNIT_MAP_SVH
`define TRAP_UNIT_MAP_SVH
// register offsets (word addresses on the plain register port)
`define OFF_TRAP_BASE      4'h0
`define OFF_MASK           4'h1
`define OFF_WIN_INVALID    4'h2
`define OFF_STATE          4'h3
`define OFF_VECTOR_MODE    4'h4
`define OFF_TRAP_STATUS    4'h5
`define OFF_SAVED_PC       4'h6
`define OFF_SAVED_NPC      4'h7
// trap base register fields
`define TBR_BASE_MSB       31
`define TBR_BASE_LSB       12
`define TBR_TT_MSB         11
`define TBR_TT_LSB         4
// processor state register fields
`define PSR_ET_BIT         5
`define PSR_PS_BIT         6
`define PSR_S_BIT          7
`define PSR_CWP_MSB        2
`define PSR_CWP_LSB        0
// trap type numbers
`define TT_BREAKPOINT      8'h0FF
`define TT_INST_ACCESS     8'h01
`define TT_ILLEGAL         8'h02
`define TT_PRIVILEGED      8'h03
`define TT_FP_DISABLED     8'h04
`define TT_WIN_OVERFLOW    8'h05
`define TT_WIN_UNDERFLOW   8'h06
`define TT_NOT_ALIGNED     8'h07
`define TT_DATA_ACCESS     8'h09
`define TT_TAG_OVERFLOW    8'h0A
`define TT_CP_DISABLED     8'h24
`define TT_TICC_BASE       8'h80
`define TT_IRQ_BASE        8'h10
// reset values
`define RST_STATE          32'h0000_0080
`define RESET_VECTOR       32'h0000_0000
// control writes land three instruction cycles later
`define CTRL_WRITE_DELAY   2'h3
`define NUM_WINDOWS        8
`endif

// file: src/trap_unit_pkg.sv
package trap_unit_pkg;
  // synchronous trap causes raised by the pipeline for the instruction in execute
  typedef struct packed {
    logic       breakpoint;
    logic       instAccess;
    logic       fpInstr;
    logic       cpInstr;
    logic       illegal;
    logic       privAsi;
    logic       saveInstr;
    logic       restoreInstr;
    logic [1:0] accessSize;
    logic       memAccess;
    logic       dataAccess;
    logic       tagTrapOp;
    logic       ticcTaken;
    logic [6:0] ticcNumber;
  } exc_cause_type;
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] npc;
    logic [31:0] addr;
    logic [31:0] opA;
    logic [31:0] opB;
  } exc_info_type;
  typedef enum logic [1:0] {
    RUN   = 2'b00,
    ENTER = 2'b01,
    FETCH = 2'b11
  } trap_state_type;
endpackage : trap_unit_pkg

// file: verification/irq_source_model.sv
`timescale 1ns/100ps
// ==========
// interrupt sources: a raised level stays up until its own trap is taken
module irq_source_model
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // raise requests from the bench, acknowledge seen from the unit
  input  wire logic [15:1] raiseReq,
  input  wire logic        flushPipe,
  input  wire logic [7:0]  trapTypeOut,
  // level request lines
  output logic [15:1]      irqLevel
);
  // a level is dropped only on its own acknowledge, so shared levels stay fair
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      irqLevel <= '0;
    else
      for (int n = 1; n < 16; n++)
        if (raiseReq[n])
          irqLevel[n] <= 1'b1;
        else if (flushPipe && trapTypeOut == 8'(16 + n))
          irqLevel[n] <= 1'b0;
endmodule : irq_source_model

// file: verification/trap_and_interrupt_unit_tb_top.sv
`timescale 1ns/100ps
module trap_and_interrupt_unit_tb_top;
  // ==========
  // signals
  logic                         sys_clk;
  logic                         rst;
  logic [15:1]                  irqLevel;
  logic [15:1]                  raiseReq;
  logic                         execValid;
  trap_unit_pkg::exc_cause_type excCause;
  trap_unit_pkg::exc_info_type  excInfo;
  logic                         refillWordDone;
  logic                         returnFromTrap;
  logic                         returnSkip;
  logic [3:0]                   regAddr;
  logic [31:0]                  regWrData;
  logic                         regWrite;
  logic                         regRead;
  logic [31:0]                  regRdData;
  logic                         flushPipe;
  logic                         instrCommit;
  logic                         redirectValid;
  logic [31:0]                  redirectPc;
  logic                         refillAbort;
  logic                         tagOverflowFlag;
  logic [7:0]                   trapTypeOut;
  logic [31:0]                  tableBase = 32'h0001_2000;
  int                           err_count = 0;
  int                           compares = 0;

  trap_and_interrupt_unit DUT (.sys_clk, .rst, .irqLevel, .execValid, .excCause, .excInfo,
    .refillWordDone, .returnFromTrap, .returnSkip, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .flushPipe, .instrCommit, .redirectValid, .redirectPc, .refillAbort,
    .tagOverflowFlag, .trapTypeOut);
  irq_source_model sources (.sys_clk, .rst, .raiseReq, .flushPipe, .trapTypeOut, .irqLevel);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========
  // shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : reg_read

  // retire plain instructions; this is also what ages delayed control writes
  task step(input int n);
    @(posedge sys_clk);
    execValid <= 1'b1;
    repeat (n) @(posedge sys_clk);
    execValid <= 1'b0;
  endtask : step

  task issue(input trap_unit_pkg::exc_cause_type c, output logic taken);
    @(posedge sys_clk);
    execValid <= 1'b1;
    excCause <= c;
    @(posedge sys_clk);
    execValid <= 1'b0;
    excCause <= '0;
    #1 taken = flushPipe;
  endtask : issue

  task entered(input logic [7:0] tt, input logic [31:0] pc);
    check(trapTypeOut, tt);
    check(redirectPc, pc);
    repeat (2) @(posedge sys_clk);
  endtask : entered

  task ret(input logic skip);
    @(posedge sys_clk);
    returnFromTrap <= 1'b1;
    returnSkip <= skip;
    @(posedge sys_clk);
    returnFromTrap <= 1'b0;
    returnSkip <= 1'b0;
    #1 check(redirectPc, skip ? excInfo.npc : excInfo.pc);
    repeat (2) @(posedge sys_clk);
  endtask : ret

  task wait_flush(input int n, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++)
    begin
      @(posedge sys_clk);
      #1 seen = flushPipe;
    end
  endtask : wait_flush

  // ==========
  // scenarios
  task reset_and_enable;
    logic [31:0] d;
    logic        t;
    #1 check(redirectPc, 32'h0000_0000);
    issue(21'h04_0000, t);
    check(t, 1'b0);
    check(tagOverflowFlag, 1'b1);
    reg_write(4'h0, tableBase);
    reg_write(4'h3, 32'h0000_00A7);
    reg_read(4'h3, d);
    check(d, 32'h0000_0080);
    step(4);
    reg_read(4'h3, d);
    check(d, 32'h0000_00A7);
  endtask : reset_and_enable

  // causes pile up from lowest to highest; the newest one must always win
  task priority_ladder;
    trap_unit_pkg::exc_cause_type c;
    logic [7:0]                   tt [9] = '{8'h85, 8'h0A, 8'h09, 8'h07, 8'h24, 8'h04, 8'h02,
                                             8'h01, 8'hFF};
    int                           pos [9] = '{7, 8, 9, 10, 17, 18, 16, 19, 20};
    logic [31:0]                  d;
    logic                         t;
    c = '0;
    c.accessSize = 2'h2;
    c.ticcNumber = 7'h05;
    for (int i = 0; i < 9; i++)
    begin
      c[pos[i]] = 1'b1;
      issue(c, t);
      check(t, 1'b1);
      entered(tt[i], tableBase | {20'h0_0000, tt[i], 4'h0});
      reg_read(4'h3, d);
      check(d, 32'h0000_00C6);
      reg_read(4'h0, d);
      check(d, tableBase | {20'h0_0000, tt[i], 4'h0});
      ret(i[0]);
    end
  endtask : priority_ladder

  task take_irq(input int lvl, input logic [7:0] tt);
    logic t;
    @(posedge sys_clk);
    raiseReq[lvl] <= 1'b1;
    @(posedge sys_clk);
    raiseReq <= '0;
    wait_flush(20, t);
    if (!t)
    begin
      err_count++;
      summarize;
    end
    check(refillAbort, refillWordDone);
    entered(tt, tableBase | {20'h0_0000, tt, 4'h0});
  endtask : take_irq

  task irq_levels;
    logic t;
    reg_write(4'h1, 32'h0000_0008);
    step(4);
    @(posedge sys_clk);
    raiseReq[3] <= 1'b1;
    take_irq(9, 8'h19);
    ret(1'b0);
    wait_flush(10, t);
    check(t, 1'b0);
    reg_write(4'h1, 32'h0000_FFFE);
    step(4);
    refillWordDone <= 1'b1;
    take_irq(15, 8'h1F);
    #1 check(trapTypeOut, 8'h1F);
    refillWordDone <= 1'b0;
    ret(1'b0);
  endtask : irq_levels

  task single_vector;
    logic [31:0] d;
    logic        t;
    reg_write(4'h4, 32'h0000_0001);
    step(4);
    reg_read(4'h4, d);
    check(d, 32'h0000_0001);
    issue(21'h04_0000, t);
    check(t, 1'b1);
    entered(8'h04, tableBase);
    ret(1'b1);
  endtask : single_vector

  initial
  begin
    rst = 1'b1;
    raiseReq = '0;
    execValid = 1'b0;
    excCause = '0;
    excInfo = '0;
    excInfo.pc = 32'h0000_1000;
    excInfo.npc = 32'h0000_1004;
    excInfo.addr = 32'h0000_0102;
    excInfo.opA = 32'h0000_0001;
    refillWordDone = 1'b0;
    returnFromTrap = 1'b0;
    returnSkip = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    reset_and_enable;
    priority_ladder;
    irq_levels;
    single_vector;
    summarize;
  end
endmodule : trap_and_interrupt_unit_tb_top

// file: verification/trap_unit_checker_sva.sv
`timescale 1ns/100ps
// ==========
// port checker for the trap unit
module trap_unit_checker
(
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst,
  // pipeline side
  input wire logic                         execValid,
  input wire trap_unit_pkg::exc_cause_type excCause,
  input wire logic                         returnFromTrap,
  // pipeline control
  input wire logic                         flushPipe,
  input wire logic                         instrCommit,
  input wire logic                         redirectValid,
  input wire logic [31:0]                  redirectPc,
  input wire logic                         refillAbort,
  input wire logic [7:0]                   trapTypeOut
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff rst;

  a_trap_redirects: assert property (flushPipe |-> redirectValid)
    else $error("trap taken without redirect");
  a_vector_offset: assert property (flushPipe |-> redirectPc[3:0] == 4'h0)
    else $error("handler address not on a table slot");
  // the two entry cycles after a trap refuse a second one
  a_no_double_trap: assert property (flushPipe && !$past(rst) |=> !flushPipe [*2])
    else $error("second trap inside entry window");
  a_squash_commit: assert property (!(flushPipe && instrCommit))
    else $error("trapped instruction retired");
  a_refill_irq: assert property (refillAbort |-> flushPipe && trapTypeOut inside {[8'h11:8'h1F]})
    else $error("refill abort without interrupt");
  a_bkpt_first: assert property (flushPipe && $past(execValid && excCause.breakpoint)
    |-> trapTypeOut == 8'hFF)
    else $error("breakpoint lost priority");
  a_fp_trap: assert property (flushPipe && $past(execValid && excCause.fpInstr
    && !excCause.breakpoint && !excCause.instAccess && !excCause.illegal && !excCause.privAsi)
    |-> trapTypeOut == 8'h04)
    else $error("float op did not trap type 4");
  a_irq_type: assert property (flushPipe && !$past(execValid) && !$past(rst)
    |-> trapTypeOut inside {[8'h11:8'h1F]})
    else $error("interrupt type out of range");
  a_reset_fetch: assert property ($fell(rst) |-> redirectValid && redirectPc == 32'h0000_0000)
    else $error("reset did not fetch from zero");
  a_return_redirect: assert property (returnFromTrap |=> redirectValid)
    else $error("return without redirect");
endmodule : trap_unit_checker

bind trap_and_interrupt_unit trap_unit_checker chk (.sys_clk, .rst, .execValid, .excCause,
  .returnFromTrap, .flushPipe, .instrCommit, .redirectValid, .redirectPc, .refillAbort,
  .trapTypeOut);
